//--- rssa_alu.sv
// Rotate, subtract and skip datapath of an 8-bit core.
// Assumes the decoder presents one operation per cycle with its memory byte.
// Assumes the sequencer squashes the next fetch while skip_next is high.
// Assumes the memory port writes mem_wdata on the edge after mem_we.
//
// How it works
// - rotate left via carry into accumulator
// - rotate memory right, bit 0 wraps
// - rotate right into accumulator, no flags
// - rotate memory right through carry
// - rotate right through carry into accumulator
// - subtract memory and inverted carry
// - subtract immediate and inverted carry
// - borrow subtract written back to memory
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - byte set writes all ones
// - bit set forces chosen bit
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - skip when chosen bit is one
// - rewrite byte, skip when nonzero
// - subtract memory from accumulator
// - subtract written back to memory
// - subtract immediate from accumulator
// - swap nibbles in memory
// - swap nibbles into accumulator
// - rewrite byte, skip when zero
//
// All results appear one cycle after the request is taken.
// mem_we and skip_next are one-cycle pulses; acc, flags and mem_wdata
// hold until the next operation changes them.
// A request presented while busy is high is ignored and must be
// presented again.
`timescale 1ns/10ps
module rssa_alu (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire rssa_pkg::rssa_req_t req,
   output logic [7:0] acc,
   output rssa_pkg::rssa_flags_t flags,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic skip_next,
   output logic busy
);

   // ****************************************
   // Decode helpers
   // ****************************************

   // Small decoders kept as functions so every process decodes alike.
   // is_sub groups the six subtract forms; nib_swap is shared by both
   // nibble exchange forms so the two cannot drift apart.

   // True for the subtract family
   function automatic logic is_sub(input rssa_pkg::rssa_op_t op);
      is_sub = (op == rssa_pkg::OP_SUBTRACT_WITH_BORROW) ||
               (op == rssa_pkg::OP_SUBTRACT_WITH_BORROW_IMM) ||
               (op == rssa_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM) ||
               (op == rssa_pkg::OP_PLAIN_SUBTRACT) ||
               (op == rssa_pkg::OP_PLAIN_SUBTRACT_TO_MEM) ||
               (op == rssa_pkg::OP_PLAIN_SUBTRACT_IMM);
   endfunction

   // Swap the two nibbles of a byte
   function automatic logic [7:0] nib_swap(input logic [7:0] v);
      nib_swap = {v[3:0], v[7:4]};
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   // Each state group has its own flip-flop process below, so a change
   // to the flag logic cannot disturb the accumulator or the write port.
   // Every _d value is settled by the combinational decode further down.
   logic [7:0] acc_q; // Accumulator
   logic [7:0] acc_d; // Accumulator next value
   rssa_pkg::rssa_flags_t flags_q; // Status flags
   rssa_pkg::rssa_flags_t flags_d; // Status flags next value
   logic [7:0] wdata_q; // Memory write data
   logic [7:0] wdata_d; // Memory write data next value
   logic we_q; // Memory write strobe
   logic we_d; // Memory write strobe next value
   logic skip_q; // Skip request toward sequencer
   logic skip_d; // Skip request next value

   // Skip sequencing: Gray along idle -> dummy -> idle
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_DUMMY = 1'b1
   } rssa_state_t;
   rssa_state_t state_q; // Sequencer state
   rssa_state_t state_d; // Sequencer next state
   // Two states suffice: a taken skip costs exactly one dummy cycle,
   // so a wider counter would add gates and nothing else.

   // ****************************************
   // Subtractor
   // ****************************************
   // Operands and results of the shared subtractor
   logic [7:0] sub_b; // Subtrahend
   logic sub_borrow; // Borrow in, the inverted carry
   logic [7:0] sub_diff; // Difference
   rssa_pkg::rssa_flags_t sub_flags; // Flags from subtract

   // The borrow forms feed the inverted carry as borrow, so a set carry
   // means no borrow pending. The plain forms feed a zero borrow.
   // Immediate forms take imm_data instead of the memory byte; every
   // other operation leaves the subtractor on the memory byte, and outside
   // the subtract family its result is then simply not used.

   // Operand select for the subtractor
   always_comb begin
      sub_b = req.mem_data;
      sub_borrow = 1'b0;
      unique case (req.op)
         rssa_pkg::OP_SUBTRACT_WITH_BORROW: sub_borrow = ~flags_q.carry;
         rssa_pkg::OP_SUBTRACT_WITH_BORROW_IMM: begin
            sub_b = req.imm_data;
            sub_borrow = ~flags_q.carry;
         end
         rssa_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM: sub_borrow = ~flags_q.carry;
         rssa_pkg::OP_PLAIN_SUBTRACT_IMM: sub_b = req.imm_data;
         default: begin
            // Memory operand, no borrow
         end
      endcase
   end

   // One shared subtractor serves all six forms; its flags are copied
   // only by a subtract, so other operations see it as idle logic.
   // zero_in carries the previous zero flag for the chained zero flag.
   rssa_sub_unit rssa_sub_unit_i (
      .a(acc_q),
      .b(sub_b),
      .borrow_in(sub_borrow),
      .zero_in(flags_q.zero),
      .diff(sub_diff),
      .flags(sub_flags)
   );

   // ****************************************
   // Datapath
   // ****************************************
   // Working values for the datapath decode
   logic [7:0] m; // Memory operand
   logic [7:0] dec_v; // Memory minus one
   logic [7:0] inc_v; // Memory plus one
   logic [7:0] bit_mask; // One-hot selected bit

   // Defaults hold acc, flags and write data and leave both pulses low,
   // so each operation only names what it changes.
   // Nothing is decoded in the dummy cycle: a request presented then is
   // dropped, and the core must issue it again.
   // Undefined codes fall to the default arm and act as a no-operation.
   // The two byte tests write the byte back unchanged, which keeps the
   // memory port timing the same as for the read-modify-write forms.
   // Hazard: m is read in every arm but byte set, the immediate subtracts and no operation, so it must be valid with req_valid.

   // Next values for accumulator, flags, memory write and skip
   always_comb begin
      m = req.mem_data;
      dec_v = m - rssa_pkg::BYTE_ONE;
      inc_v = m + rssa_pkg::BYTE_ONE;
      bit_mask = rssa_pkg::BYTE_ONE << req.bit_sel;
      acc_d = acc_q;
      flags_d = flags_q;
      wdata_d = wdata_q;
      we_d = 1'b0;
      skip_d = 1'b0;
      if (req_valid && state_q == ST_RUN) begin
         unique case (req.op)
            // Rotates: wiring only; the carry forms also load the carry flag
            rssa_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: begin
               acc_d = {m[6:0], flags_q.carry};
               flags_d.carry = m[rssa_pkg::MSB_POS];
            end
            rssa_pkg::OP_ROTATE_RIGHT_IN_PLACE: begin
               wdata_d = {m[0], m[7:1]};
               we_d = 1'b1;
            end
            rssa_pkg::OP_ROTATE_RIGHT_TO_ACC: acc_d = {m[0], m[7:1]};
            rssa_pkg::OP_ROTATE_RIGHT_CARRY_IN_PLACE: begin
               wdata_d = {flags_q.carry, m[7:1]};
               we_d = 1'b1;
               flags_d.carry = m[rssa_pkg::LSB_POS];
            end
            rssa_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
               acc_d = {flags_q.carry, m[7:1]};
               flags_d.carry = m[rssa_pkg::LSB_POS];
            end
            // Subtracts: accumulator or memory destination, six flags
            rssa_pkg::OP_SUBTRACT_WITH_BORROW,
            rssa_pkg::OP_SUBTRACT_WITH_BORROW_IMM,
            rssa_pkg::OP_PLAIN_SUBTRACT,
            rssa_pkg::OP_PLAIN_SUBTRACT_IMM: begin
               acc_d = sub_diff;
               flags_d = sub_flags;
            end
            rssa_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM,
            rssa_pkg::OP_PLAIN_SUBTRACT_TO_MEM: begin
               wdata_d = sub_diff;
               we_d = 1'b1;
               flags_d = sub_flags;
            end
            // Step and skip: skip raised when the new value is zero
            rssa_pkg::OP_DECREMENT_SKIP_ZERO: begin
               wdata_d = dec_v;
               we_d = 1'b1;
               skip_d = (dec_v == rssa_pkg::BYTE_ZERO);
            end
            rssa_pkg::OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
               acc_d = dec_v;
               skip_d = (dec_v == rssa_pkg::BYTE_ZERO);
            end
            // Set forms: no flag is touched
            rssa_pkg::OP_BYTE_SET: begin
               wdata_d = rssa_pkg::BYTE_ALL_ONES;
               we_d = 1'b1;
            end
            rssa_pkg::OP_BIT_SET: begin
               wdata_d = m | bit_mask;
               we_d = 1'b1;
            end
            rssa_pkg::OP_INCREMENT_SKIP_ZERO: begin
               wdata_d = inc_v;
               we_d = 1'b1;
               skip_d = (inc_v == rssa_pkg::BYTE_ZERO);
            end
            rssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
               acc_d = inc_v;
               skip_d = (inc_v == rssa_pkg::BYTE_ZERO);
            end
            // Tests: no flag is touched
            rssa_pkg::OP_SKIP_IF_BIT_NONZERO: skip_d = |(m & bit_mask);
            rssa_pkg::OP_SKIP_IF_NONZERO: begin
               wdata_d = m;
               we_d = 1'b1;
               skip_d = (m != rssa_pkg::BYTE_ZERO);
            end
            // Nibble exchange, in place or into the accumulator
            rssa_pkg::OP_NIBBLE_EXCHANGE_IN_PLACE: begin
               wdata_d = nib_swap(m);
               we_d = 1'b1;
            end
            rssa_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: acc_d = nib_swap(m);
            rssa_pkg::OP_SKIP_IF_ZERO: begin
               wdata_d = m;
               we_d = 1'b1;
               skip_d = (m == rssa_pkg::BYTE_ZERO);
            end
            default: begin
               // No operation
            end
         endcase
      end
   end

   // ****************************************
   // Skip sequencer
   // ****************************************

   // The skip decision comes from skip_d, the same term that loads
   // skip_q, so the dummy cycle always lines up with the skip pulse.
   // A skip that is not taken stays in ST_RUN and costs no extra cycle.
   // busy is high for exactly the cycle in which skip_next is high.

   // A taken skip adds one dummy cycle; otherwise one cycle
   always_comb begin
      state_d = ST_RUN;
      unique case (state_q)
         ST_RUN: state_d = skip_d ? ST_DUMMY : ST_RUN;
         ST_DUMMY: state_d = ST_RUN;
      endcase
   end

   // Sequencer state register
   // Reset leaves the sequencer ready for a request
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Accumulator register
   // Reset value is a chosen constant; software should not rely on it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= rssa_pkg::ACC_RESET;
      end else begin
         acc_q <= acc_d;
      end
   end

   // Flag register
   // All six flags clear on reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= rssa_pkg::FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   // Memory write port register
   // Strobe clears on reset so no stray write follows it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdata_q <= rssa_pkg::BYTE_ZERO;
         we_q <= 1'b0;
      end else begin
         wdata_q <= wdata_d;
         we_q <= we_d;
      end
   end

   // Skip pulse register
   // Cleared on reset so no fetch is squashed after it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_q <= 1'b0;
      end else begin
         skip_q <= skip_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Data outputs come straight from flip-flops, so the core sees clean
   // values a full cycle before its next edge. busy alone is decoded
   // from the state register, one gate deep, as a handshake output.
   // mem_wdata keeps its last value between writes.
   assign acc = acc_q;
   assign flags = flags_q;
   assign mem_wdata = wdata_q;
   assign mem_we = we_q;
   assign skip_next = skip_q;
   assign busy = (state_q == ST_DUMMY); // Dummy cycle, request ignored

endmodule // rssa_alu

//--- rssa_alu_checker.sv
// Concurrent checks on the rotate/subtract/skip datapath ports.
// Assumes it is bound onto rssa_alu and sees only its ports.
`timescale 1ns/10ps
module rssa_alu_checker (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire rssa_pkg::rssa_req_t req,
   input wire logic [7:0] acc,
   input wire rssa_pkg::rssa_flags_t flags,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_we,
   input wire logic skip_next,
   input wire logic busy
);
   // ****************************************
   // Clocking and accepted request
   // ****************************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic tk; // Request accepted at this edge
   assign tk = req_valid && !busy;

   property p_dec;
      tk && req.op == rssa_pkg::OP_DECREMENT_SKIP_ZERO && req.mem_data == 8'h01
      |=> mem_we && mem_wdata == 8'h00 && skip_next;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement skip wrong");
   property p_inc;
      tk && req.op == rssa_pkg::OP_INCREMENT_SKIP_ZERO && req.mem_data == 8'hff
      |=> mem_we && mem_wdata == 8'h00 && skip_next;
   endproperty
   a_inc: assert property (p_inc) else $error("increment skip wrong");
   property p_skp;
      skip_next |-> busy ##1 !busy;
   endproperty
   a_skp: assert property (p_skp) else $error("dummy cycle wrong");
   property p_rr;
      tk && req.op == rssa_pkg::OP_ROTATE_RIGHT_IN_PLACE |=> mem_we && $stable(flags)
      && mem_wdata == {$past(req.mem_data[0]), $past(req.mem_data[7:1])};
   endproperty
   a_rr: assert property (p_rr) else $error("rotate right wrong");
   property p_rra;
      tk && req.op == rssa_pkg::OP_ROTATE_RIGHT_TO_ACC |=> !skip_next && !busy
      && !mem_we && acc == {$past(req.mem_data[0]), $past(req.mem_data[7:1])};
   endproperty
   a_rra: assert property (p_rra) else $error("rotate to acc wrong");
   property p_set;
      tk && req.op == rssa_pkg::OP_BYTE_SET |=> mem_we && mem_wdata == 8'hff && $stable(flags);
   endproperty
   a_set: assert property (p_set) else $error("byte set wrong");
   property p_swa;
      tk && req.op == rssa_pkg::OP_NIBBLE_EXCHANGE_TO_ACC |=> !mem_we
      && acc == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])};
   endproperty
   a_swa: assert property (p_swa) else $error("swap to acc wrong");
   property p_rlc;
      tk && req.op == rssa_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC |=> !mem_we
      && acc == {$past(req.mem_data[6:0]), $past(flags.carry)} && flags.carry == $past(req.mem_data[7]);
   endproperty
   a_rlc: assert property (p_rlc) else $error("rotate left wrong");
   property p_bnz;
      tk && req.op == rssa_pkg::OP_SKIP_IF_BIT_NONZERO |=> skip_next == $past(req.mem_data[req.bit_sel]);
   endproperty
   a_bnz: assert property (p_bnz) else $error("bit test skip wrong");
endmodule // rssa_alu_checker

bind rssa_alu rssa_alu_checker rssa_alu_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .req_valid(req_valid), .req(req), .acc(acc), .flags(flags), .mem_wdata(mem_wdata),
   .mem_we(mem_we), .skip_next(skip_next), .busy(busy));

//--- rssa_pkg.sv
// Package for the rotate/subtract/skip datapath: operation codes, flag layout,
// reset values and cycle counts.
// Assumes a single 50 MHz instruction clock and no bus.
package rssa_pkg;

   // Operation codes issued by the core's decoder
   typedef enum logic [4:0] {
      OP_NONE = 5'h00,
      OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h01,
      OP_ROTATE_RIGHT_IN_PLACE = 5'h02,
      OP_ROTATE_RIGHT_TO_ACC = 5'h03,
      OP_ROTATE_RIGHT_CARRY_IN_PLACE = 5'h04,
      OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h05,
      OP_SUBTRACT_WITH_BORROW = 5'h06,
      OP_SUBTRACT_WITH_BORROW_IMM = 5'h07,
      OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h08,
      OP_DECREMENT_SKIP_ZERO = 5'h09,
      OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h0a,
      OP_BYTE_SET = 5'h0b,
      OP_BIT_SET = 5'h0c,
      OP_INCREMENT_SKIP_ZERO = 5'h0d,
      OP_INCREMENT_SKIP_ZERO_TO_ACC = 5'h0e,
      OP_SKIP_IF_BIT_NONZERO = 5'h0f,
      OP_SKIP_IF_NONZERO = 5'h10,
      OP_PLAIN_SUBTRACT = 5'h11,
      OP_PLAIN_SUBTRACT_TO_MEM = 5'h12,
      OP_PLAIN_SUBTRACT_IMM = 5'h13,
      OP_NIBBLE_EXCHANGE_IN_PLACE = 5'h14,
      OP_NIBBLE_EXCHANGE_TO_ACC = 5'h15,
      OP_SKIP_IF_ZERO = 5'h16
   } rssa_op_t;

   // Status flags held by this block
   typedef struct packed {
      logic aux_status_flag_two;
      logic aux_status_flag_one;
      logic carry;
      logic auxiliary_carry_flag;
      logic zero;
      logic overflow_flag;
   } rssa_flags_t;

   // One issued instruction
   typedef struct packed {
      rssa_op_t op;
      logic [7:0] mem_data;
      logic [7:0] imm_data;
      logic [2:0] bit_sel;
   } rssa_req_t;

   // Reset values and byte constants
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam rssa_flags_t FLAGS_RESET = 6'h00;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;

   // Field positions
   localparam int unsigned MSB_POS = 7;
   localparam int unsigned LSB_POS = 0;

   // Cycle counts
   localparam logic [1:0] CYCLES_NORMAL = 2'h1;
   localparam logic [1:0] CYCLES_SKIP = 2'h2;

endpackage : rssa_pkg

//--- rssa_sub_unit.sv
// Subtract unit: a - b - borrow with the six arithmetic flags.
// Assumes an 8-bit operand pair; purely combinational.
`timescale 1ns/10ps
module rssa_sub_unit (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic borrow_in,
   input wire logic zero_in,
   output logic [7:0] diff,
   output rssa_pkg::rssa_flags_t flags
);

   // ****************************************
   // Arithmetic
   // ****************************************
   logic [8:0] full; // Nine-bit difference, bit 8 is borrow out
   logic [4:0] low; // Low nibble difference, bit 4 is half borrow
   logic ov; // Signed overflow

   // Difference and flags
   always_comb begin
      full = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
      low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
      diff = full[7:0];
      ov = (a[7] ^ b[7]) & (a[7] ^ full[7]);
      flags.carry = ~full[8];
      flags.auxiliary_carry_flag = ~low[4];
      flags.overflow_flag = ov;
      flags.zero = (full[7:0] == 8'h00);
      flags.aux_status_flag_one = full[7] ^ ov;
      flags.aux_status_flag_two = (full[7:0] == 8'h00) & zero_in;
   end

endmodule // rssa_sub_unit

//--- test_rotate_subtract_skip_alu.sv
// Self-checking bench for the rotate/subtract/skip datapath.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
module test_rotate_subtract_skip_alu;
   // ****************************************
   // Signals and expected-value model state
   // ****************************************
   logic ref_clk = 0, rst_n = 0, req_valid = 0, vld_q = 0;
   rssa_pkg::rssa_req_t req = '0;
   logic [7:0] acc, mem_wdata;
   rssa_pkg::rssa_flags_t flags;
   logic mem_we, skip_next, busy;
   logic [23:0] notes[$]; // Expected {acc, flags, we, wdata, skip}
   logic [23:0] n = '0; // Current expectation, reset values at start
   logic [7:0] e_acc = 0, e_wd = 0;
   rssa_pkg::rssa_flags_t e_f = '0;
   int errors = 0, check_count = 0;

   rssa_alu rssa_alu_i (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .acc(acc), .flags(flags), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .skip_next(skip_next), .busy(busy));

   initial forever #10 ref_clk = ~ref_clk;

   // Issue one operation, note its expected result, fill the dummy cycle
   task automatic issue(input rssa_pkg::rssa_op_t op, input logic [7:0] m, input logic [7:0] x,
         input logic [2:0] b);
      logic [7:0] a, r, y, wd;
      logic [8:0] d;
      logic [4:0] h;
      logic we, sk, bin;
      a = e_acc;
      {we, sk, wd} = {2'h0, m};
      case (op)
         rssa_pkg::OP_ROTATE_LEFT_CARRY_TO_ACC: {e_acc, e_f.carry} = {m[6:0], e_f.carry, m[7]};
         rssa_pkg::OP_ROTATE_RIGHT_IN_PLACE: {we, wd} = {1'b1, m[0], m[7:1]};
         rssa_pkg::OP_ROTATE_RIGHT_TO_ACC: e_acc = {m[0], m[7:1]};
         rssa_pkg::OP_ROTATE_RIGHT_CARRY_IN_PLACE: {we, wd, e_f.carry} = {1'b1, e_f.carry, m};
         rssa_pkg::OP_ROTATE_RIGHT_CARRY_TO_ACC: {e_acc, e_f.carry} = {e_f.carry, m};
         rssa_pkg::OP_DECREMENT_SKIP_ZERO: {we, wd, sk} = {1'b1, m - 8'h01, m == 8'h01};
         rssa_pkg::OP_DECREMENT_SKIP_ZERO_TO_ACC: {e_acc, sk} = {m - 8'h01, m == 8'h01};
         rssa_pkg::OP_INCREMENT_SKIP_ZERO: {we, wd, sk} = {1'b1, m + 8'h01, m == 8'hff};
         rssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_ACC: {e_acc, sk} = {m + 8'h01, m == 8'hff};
         rssa_pkg::OP_BYTE_SET: {we, wd} = {1'b1, 8'hff};
         rssa_pkg::OP_BIT_SET: {we, wd} = {1'b1, m | (8'h01 << b)};
         rssa_pkg::OP_SKIP_IF_BIT_NONZERO: sk = m[b];
         rssa_pkg::OP_SKIP_IF_NONZERO: {we, sk} = {1'b1, m != 8'h00};
         rssa_pkg::OP_SKIP_IF_ZERO: {we, sk} = {1'b1, m == 8'h00};
         rssa_pkg::OP_NIBBLE_EXCHANGE_IN_PLACE: {we, wd} = {1'b1, m[3:0], m[7:4]};
         rssa_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: e_acc = {m[3:0], m[7:4]};
         default: begin
            // Subtract family: carry set means no borrow
            y = (op inside {rssa_pkg::OP_SUBTRACT_WITH_BORROW_IMM,
               rssa_pkg::OP_PLAIN_SUBTRACT_IMM}) ? x : m;
            bin = !e_f.carry && (op inside {rssa_pkg::OP_SUBTRACT_WITH_BORROW,
               rssa_pkg::OP_SUBTRACT_WITH_BORROW_IMM, rssa_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM});
            d = {1'b0, a} - {1'b0, y} - 9'(bin);
            h = {1'b0, a[3:0]} - {1'b0, y[3:0]} - 5'(bin);
            r = d[7:0];
            e_f.overflow_flag = (a[7] ^ y[7]) & (a[7] ^ r[7]);
            e_f.aux_status_flag_one = r[7] ^ e_f.overflow_flag;
            e_f.aux_status_flag_two = (r == 8'h00) & e_f.zero;
            e_f.zero = (r == 8'h00);
            e_f.carry = !d[8];
            e_f.auxiliary_carry_flag = !h[4];
            if (op inside {rssa_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM,
               rssa_pkg::OP_PLAIN_SUBTRACT_TO_MEM}) {we, wd} = {1'b1, r};
            else e_acc = r;
         end
      endcase
      if (we) e_wd = wd;
      notes.push_back({e_acc, e_f, we, e_wd, sk});
      @(posedge ref_clk);
      #1;
      req_valid = 1;
      req = '{op, m, x, b};
      if (sk) begin
         // Request during the dummy cycle must be ignored
         @(posedge ref_clk);
         #1;
         req.op = rssa_pkg::rssa_op_t'(5'($urandom_range(22, 1)));
      end
   endtask

   task automatic idle();
      @(posedge ref_clk);
      #1;
      req_valid = 0;
   endtask

   // ****************************************
   // Watcher: compare outputs every cycle
   // ****************************************
   always @(posedge ref_clk) vld_q <= rst_n && req_valid && !busy;
   always @(negedge ref_clk) begin
      if (vld_q) n = notes.pop_front();
      else {n[9], n[0]} = 2'h0; // Idle: pulses low, state holds
      check_count++;
      if ({acc, flags, mem_we, mem_wdata, skip_next, busy} !== {n, n[0]}) begin
         errors++;
         $display("mismatch %0t exp %h got %h", $time, {n, n[0]},
            {acc, flags, mem_we, mem_wdata, skip_next, busy});
      end
   end

   task automatic finish_test();
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      void'($urandom(96911));
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1;
      issue(rssa_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01, 8'h00, 3'h0);
      issue(rssa_pkg::OP_DECREMENT_SKIP_ZERO_TO_ACC, 8'h01, 8'h00, 3'h0);
      issue(rssa_pkg::OP_INCREMENT_SKIP_ZERO, 8'hff, 8'h00, 3'h0);
      issue(rssa_pkg::OP_INCREMENT_SKIP_ZERO_TO_ACC, 8'hff, 8'h00, 3'h0);
      issue(rssa_pkg::OP_SKIP_IF_BIT_NONZERO, 8'h80, 8'h00, 3'h7);
      issue(rssa_pkg::OP_SKIP_IF_NONZERO, 8'h00, 8'h00, 3'h0);
      issue(rssa_pkg::OP_SKIP_IF_ZERO, 8'h00, 8'h00, 3'h0);
      issue(rssa_pkg::OP_ROTATE_RIGHT_TO_ACC, 8'h01, 8'h00, 3'h0);
      issue(rssa_pkg::OP_PLAIN_SUBTRACT_IMM, 8'h00, 8'h01, 3'h0);
      repeat (400) begin
         if ($urandom_range(3) == 0) idle();
         issue(rssa_pkg::rssa_op_t'(5'($urandom_range(22, 1))), 8'($urandom), 8'($urandom),
            3'($urandom));
      end
      idle();
      idle();
      finish_test();
   end

   initial begin
      #100000;
      errors++;
      finish_test();
   end
endmodule // test_rotate_subtract_skip_alu
